// ===== hw/apc_regs.svh
`ifndef APC_REGS_SVH
`define APC_REGS_SVH

// ****************************************************************
// register offsets (byte-wide registers)
// ****************************************************************
`define APC_ADDR_W 9
`define APC_OFS_DIV_EN_BYP 9'h100
`define APC_OFS_FAST_DIVS 9'h101
`define APC_OFS_SRC_SEL 9'h102
`define APC_OFS_PHASE_STEP 9'h103
`define APC_OFS_NUM_BYTE0 9'h106
`define APC_NUM_BYTES 6
`define APC_NUM_LAST 5

// ****************************************************************
// field positions and widths
// ****************************************************************
`define APC_BIT_SECOND_DIV_EN 2
`define APC_BIT_OUT_BYPASS 1
`define APC_DIV_W 4
`define APC_POS_FAST_DIV_TWO 4
`define APC_POS_FAST_DIV_ONE 0
`define APC_BIT_EXT_SWITCH 6
`define APC_SEL_W 3
`define APC_POS_ALT_SEL 3
`define APC_POS_PRI_SEL 0
`define APC_BIT_SW_DEC 7
`define APC_POS_DEC_SEL 4
`define APC_BIT_SW_INC 3
`define APC_POS_INC_SEL 0
`define APC_NUM_W 42
`define APC_NUM_TOP_MASK 8'h03

// ****************************************************************
// reset values and write masks
// ****************************************************************
`define APC_RST_DIV_EN_BYP 8'h00
`define APC_RST_FAST_DIVS 8'h00
`define APC_RST_SRC_SEL 8'h00
`define APC_RST_PHASE_STEP 8'h00
`define APC_RST_NUM_BYTE 8'h00
`define APC_MASK_DIV_EN_BYP 8'h06
`define APC_MASK_SRC_SEL 8'h7F

`endif

// ===== hw/apc_pkg.sv
package apc_pkg;

  // where the analog loop takes its reference from
  typedef enum logic [2:0] {
    APC_REF_CRYSTAL,
    APC_REF_IN_ONE,
    APC_REF_IN_TWO,
    APC_REF_IN_THREE,
    APC_REF_DPLL
  } apc_ref_e;

  // what the output bypass mux is fed with
  typedef enum logic [2:0] {
    APC_BYP_NONE,
    APC_BYP_CRYSTAL,
    APC_BYP_IN_ONE,
    APC_BYP_IN_TWO,
    APC_BYP_IN_THREE
  } apc_byp_e;

  // division ratio counted in half steps (ratio times two)
  typedef logic [4:0] apc_half_ratio_t;

  // fixed-point feedback numerator, 9 integer bits on top
  typedef logic [41:0] apc_numerator_t;

endpackage : apc_pkg

// ===== hw/apc_edge_stepper.sv
module apc_edge_stepper
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic pinLevel,
  output logic syncLevel,
  output logic edgePulse
);

  // ****************************************************************
  // two-stage synchroniser and edge detector
  // ****************************************************************
  logic metaQ; // first stage, read by syncQ only
  logic syncQ; // settled level
  logic lastQ; // level one cycle earlier

  // synchroniser chain plus history flop
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      metaQ <= 1'b0;
      syncQ <= 1'b0;
      lastQ <= 1'b0;
    end
    else
    begin
      metaQ <= pinLevel;
      syncQ <= metaQ;
      lastQ <= syncQ;
    end
  end

  // both rising and falling edges count, one pulse each
  assign syncLevel = syncQ;
  assign edgePulse = syncQ ^ lastQ;

endmodule : apc_edge_stepper

// ===== hw/apc_path_control.sv
// What this block does
// (RULE1) second divider runs only when enabled, unbypassed
// (RULE2) bypass bit picks divided or bypass signal
// (RULE3) second divider code gives 4..7.5, 8..15
// (RULE4) first divider code uses same encoding
// (RULE5) switch pin high selects alternate source field
// (RULE6) alternate field ignored without external switching
// (RULE7) alternate code picks crystal or inputs one-three
// (RULE8) primary 001-011 feeds input to loop, bypass
// (RULE9) 110 crystal bypass, 111 no bypass, DPLL ref
// (RULE10) 100 input one bypass, 101 none, DPLL ref; here 100 feeds no bypass unless masterClockFromInputOne is high
// (RULE11) software keeps bypass off with no bypass
// (RULE12) codes 0xx bypass DPLL, allow its power-down
// (RULE13) each decrement source edge steps phase earlier
// (RULE14) decrement select: software bit or pins 0-3
// (RULE15) software decrement bit used only with select 000
// (RULE16) each increment source edge steps phase later
// (RULE17) increment select: software bit or pins 0-3
// (RULE18) software increment bit used only with select 000
// (RULE19) 42-bit numerator in six bytes, LSB first
// (RULE20) software avoids zero numerator, zero unused bits
// (RULE21) software zeroes top numerator bits with DPLL
// (RULE22) denominator 32-bit, reset 1, never zero; this block holds no denominator, its offset reads zero
// (RULE23) pin sources synchronised, one step per edge
// (RULE24) numerator reaches divider only as whole value
`include "apc_regs.svh"

module apc_path_control
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [8:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic globalPllEnable,
  input wire logic masterClockFromInputOne,
  input wire logic crystalClockDoubler,
  input wire logic [1:0] switchPinSelect,
  input wire logic [3:0] gpioPin,
  output logic secondDividerRun,
  output logic outputBypassSelect,
  output apc_pkg::apc_half_ratio_t fastDividerOneRatio,
  output apc_pkg::apc_half_ratio_t fastDividerTwoRatio,
  output apc_pkg::apc_ref_e pllRefSource,
  output apc_pkg::apc_byp_e bypassSource,
  output logic bypassDoubled,
  output logic dpllPowerDownAllowed,
  output logic phaseDecStep,
  output logic phaseIncStep,
  output apc_pkg::apc_numerator_t feedbackNumerator
);

  import apc_pkg::*;

  // ****************************************************************
  // decode helpers
  // ****************************************************************

  // divider code to ratio in half steps
  function automatic apc_half_ratio_t halfRatio(input logic [3:0] code);
    logic [4:0] wide;
    wide = {1'b0, code};
    if (code[3])
      halfRatio = 5'(wide << 1); // integer ratios 8..15
    else
      halfRatio = 5'(wide + 5'h08); // 4.0 .. 7.5 in half steps
  endfunction : halfRatio

  // source code to the loop reference
  function automatic apc_ref_e refOf(input logic [2:0] code);
    case (code)
      3'h0:
        refOf = APC_REF_CRYSTAL; // crystal, or crystal pin without one
      3'h1:
        refOf = APC_REF_IN_ONE;
      3'h2:
        refOf = APC_REF_IN_TWO;
      3'h3:
        refOf = APC_REF_IN_THREE;
      default:
        refOf = APC_REF_DPLL; // 1xx always take the DPLL output
    endcase
  endfunction : refOf

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [7:0] divEnBypQ; // enable and bypass bits
  logic [7:0] fastDivsQ; // both divider codes
  logic [7:0] srcSelQ; // source selects and switching mode
  logic [7:0] phaseCtlQ; // step sources and software bits
  logic [7:0] numStageQ [0:`APC_NUM_BYTES-1]; // numerator staging
  logic numLastWr; // top numerator byte written

  // byte address hit helpers
  logic hitDivEnByp;
  logic hitFastDivs;
  logic hitSrcSel;
  logic hitPhaseCtl;
  assign hitDivEnByp = (regAddr == `APC_OFS_DIV_EN_BYP);
  assign hitFastDivs = (regAddr == `APC_OFS_FAST_DIVS);
  assign hitSrcSel = (regAddr == `APC_OFS_SRC_SEL);
  assign hitPhaseCtl = (regAddr == `APC_OFS_PHASE_STEP);
  assign numLastWr = regWrEn && (regAddr == `APC_OFS_NUM_BYTE0 + 9'(`APC_NUM_LAST));

  // control register writes; reserved bits stay zero
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      divEnBypQ <= `APC_RST_DIV_EN_BYP;
      fastDivsQ <= `APC_RST_FAST_DIVS;
      srcSelQ <= `APC_RST_SRC_SEL;
      phaseCtlQ <= `APC_RST_PHASE_STEP;
    end
    else if (regWrEn)
    begin
      if (hitDivEnByp)
        divEnBypQ <= regWrData & `APC_MASK_DIV_EN_BYP;
      if (hitFastDivs)
        fastDivsQ <= regWrData;
      if (hitSrcSel)
        srcSelQ <= regWrData & `APC_MASK_SRC_SEL;
      if (hitPhaseCtl)
        phaseCtlQ <= regWrData;
    end
  end

  // ****************************************************************
  // numerator staging and commit
  // ****************************************************************

  // bytes land in staging; nothing reaches the divider yet
  genvar gb;
  generate
    for (gb = 0; gb < `APC_NUM_BYTES; gb++)
    begin : g_stage
      always_ff @(posedge sys_clk)
      begin
        if (!nrst)
          numStageQ[gb] <= `APC_RST_NUM_BYTE;
        else if (regWrEn && (regAddr == `APC_OFS_NUM_BYTE0 + 9'(gb)))
        begin
          if (gb == `APC_NUM_LAST)
            numStageQ[gb] <= regWrData & `APC_NUM_TOP_MASK;
          else
            numStageQ[gb] <= regWrData; // RULE19
        end
      end
    end
  endgenerate

  // top byte write commits all six bytes at once, so a
  // half-written value never glitches the feedback divider
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      feedbackNumerator <= '0;
    else if (numLastWr)
      feedbackNumerator <= {regWrData[1:0], numStageQ[4], numStageQ[3], // RULE24
                            numStageQ[2], numStageQ[1], numStageQ[0]}; // RULE19
  end

  // ****************************************************************
  // read-back port
  // ****************************************************************

  // one-cycle registered read; unmapped offsets read zero
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      regRdData <= 8'h00;
    else if (regRdEn)
    begin
      if (hitDivEnByp)
        regRdData <= divEnBypQ;
      else if (hitFastDivs)
        regRdData <= fastDivsQ;
      else if (hitSrcSel)
        regRdData <= srcSelQ;
      else if (hitPhaseCtl)
        regRdData <= phaseCtlQ;
      else if (regAddr >= `APC_OFS_NUM_BYTE0 &&
               regAddr <= `APC_OFS_NUM_BYTE0 + 9'(`APC_NUM_LAST))
        regRdData <= numStageQ[3'(regAddr - `APC_OFS_NUM_BYTE0)];
      else
        regRdData <= 8'h00;
    end
  end

  // ****************************************************************
  // general-purpose pin synchronisers
  // ****************************************************************
  logic [3:0] gpioLevel; // settled pin levels
  logic [3:0] gpioEdge; // one pulse per pin edge

  // every pin is tracked all the time, so changing a select
  // never manufactures a step from stale history
  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++)
    begin : g_pin
      apc_edge_stepper u_step (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pinLevel(gpioPin[gp]),
        .syncLevel(gpioLevel[gp]),
        .edgePulse(gpioEdge[gp]) // RULE23
      );
    end
  endgenerate

  // ****************************************************************
  // source selection
  // ****************************************************************
  logic extSwitch; // external switching enabled
  logic switchHigh; // chosen pin is high
  logic [2:0] effSel; // code in force this cycle
  assign extSwitch = srcSelQ[`APC_BIT_EXT_SWITCH];
  assign switchHigh = gpioLevel[switchPinSelect];
  // alternate used only with switching on and pin high
  assign effSel = (extSwitch && switchHigh) ? // RULE5 RULE6
                  srcSelQ[`APC_POS_ALT_SEL +: `APC_SEL_W] :
                  srcSelQ[`APC_POS_PRI_SEL +: `APC_SEL_W];

  // loop reference and bypass feed, registered to the pins
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      pllRefSource <= APC_REF_CRYSTAL;
      bypassSource <= APC_BYP_CRYSTAL;
      dpllPowerDownAllowed <= 1'b1;
      bypassDoubled <= 1'b0;
    end
    else
    begin
      pllRefSource <= refOf(effSel); // RULE7 RULE8
      dpllPowerDownAllowed <= ~effSel[2]; // RULE12
      bypassDoubled <= crystalClockDoubler;
      case (effSel)
        3'h0:
          bypassSource <= APC_BYP_CRYSTAL; // RULE7
        3'h1:
          bypassSource <= APC_BYP_IN_ONE; // RULE8
        3'h2:
          bypassSource <= APC_BYP_IN_TWO; // RULE8
        3'h3:
          bypassSource <= APC_BYP_IN_THREE; // RULE8
        3'h4:
          // input one only when the master clock comes from it
          bypassSource <= masterClockFromInputOne ? APC_BYP_IN_ONE : APC_BYP_NONE; // RULE10
        3'h6:
          bypassSource <= APC_BYP_CRYSTAL; // RULE9
        default:
          bypassSource <= APC_BYP_NONE; // RULE9 RULE10 RULE11
      endcase
    end
  end

  // ****************************************************************
  // divider and bypass controls
  // ****************************************************************

  // gating the divider saves power whenever it is not needed
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      secondDividerRun <= 1'b0;
      outputBypassSelect <= 1'b0;
      fastDividerOneRatio <= halfRatio(4'h0);
      fastDividerTwoRatio <= halfRatio(4'h0);
    end
    else
    begin
      secondDividerRun <= globalPllEnable && divEnBypQ[`APC_BIT_SECOND_DIV_EN] &&
                          !divEnBypQ[`APC_BIT_OUT_BYPASS]; // RULE1
      outputBypassSelect <= divEnBypQ[`APC_BIT_OUT_BYPASS]; // RULE2
      fastDividerTwoRatio <= halfRatio(fastDivsQ[`APC_POS_FAST_DIV_TWO +: `APC_DIV_W]); // RULE3
      fastDividerOneRatio <= halfRatio(fastDivsQ[`APC_POS_FAST_DIV_ONE +: `APC_DIV_W]); // RULE4
    end
  end

  // ****************************************************************
  // phase step generation
  // ****************************************************************
  logic swDecLastQ; // software decrement bit history
  logic swIncLastQ; // software increment bit history
  logic swDecEdge;
  logic swIncEdge;
  logic [2:0] decSel;
  logic [2:0] incSel;
  logic decEdge;
  logic incEdge;

  assign decSel = phaseCtlQ[`APC_POS_DEC_SEL +: `APC_SEL_W];
  assign incSel = phaseCtlQ[`APC_POS_INC_SEL +: `APC_SEL_W];
  // toggling a software bit either way makes one edge
  assign swDecEdge = phaseCtlQ[`APC_BIT_SW_DEC] ^ swDecLastQ;
  assign swIncEdge = phaseCtlQ[`APC_BIT_SW_INC] ^ swIncLastQ;

  // software bit history, tracked even while unselected
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      swDecLastQ <= 1'b0;
      swIncLastQ <= 1'b0;
    end
    else
    begin
      swDecLastQ <= phaseCtlQ[`APC_BIT_SW_DEC];
      swIncLastQ <= phaseCtlQ[`APC_BIT_SW_INC];
    end
  end

  // decrement edge of the chosen source
  always_comb
  begin
    case (decSel)
      3'h0:
        decEdge = swDecEdge; // RULE15
      3'h1, 3'h2, 3'h3, 3'h4:
        decEdge = gpioEdge[2'(decSel - 3'h1)]; // RULE14
      default:
        decEdge = 1'b0; // unused codes never step
    endcase
  end

  // increment edge of the chosen source
  always_comb
  begin
    case (incSel)
      3'h0:
        incEdge = swIncEdge; // RULE18
      3'h1, 3'h2, 3'h3, 3'h4:
        incEdge = gpioEdge[2'(incSel - 3'h1)]; // RULE17
      default:
        incEdge = 1'b0; // unused codes never step
    endcase
  end

  // one-cycle step pulses, one per source edge
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      phaseDecStep <= 1'b0;
      phaseIncStep <= 1'b0;
    end
    else
    begin
      phaseDecStep <= decEdge; // RULE13
      phaseIncStep <= incEdge; // RULE16
    end
  end

endmodule : apc_path_control

// ===== tb/apc_path_control_assertions.sv
module apc_path_control_checker
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [8:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic globalPllEnable,
  input wire logic [3:0] gpioPin,
  input wire logic secondDividerRun,
  input wire logic outputBypassSelect,
  input wire apc_pkg::apc_half_ratio_t fastDividerOneRatio,
  input wire apc_pkg::apc_half_ratio_t fastDividerTwoRatio,
  input wire apc_pkg::apc_ref_e pllRefSource,
  input wire apc_pkg::apc_byp_e bypassSource,
  input wire logic dpllPowerDownAllowed,
  input wire logic phaseDecStep,
  input wire logic phaseIncStep,
  input wire apc_pkg::apc_numerator_t feedbackNumerator
);
  import apc_pkg::*;

  // ****
  // write decodes
  // ****
  logic wrCtl; // enable and bypass register
  logic wrDiv; // both divider codes
  logic wrSrc; // source select register
  logic wrTop; // top numerator byte, the commit point
  logic wrPhase; // phase step control register
  assign wrCtl = regWrEn && regAddr == 9'h100;
  assign wrDiv = regWrEn && regAddr == 9'h101;
  assign wrSrc = regWrEn && regAddr == 9'h102;
  assign wrTop = regWrEn && regAddr == 9'h10B;
  assign wrPhase = regWrEn && regAddr == 9'h103;

  // code to ratio in half steps, kept apart from the design's decode
  function automatic logic [4:0] halfRatio(input logic [3:0] c);
    return c[3] ? {c, 1'b0} : {2'b00, c[2:0]} + 5'h08;
  endfunction : halfRatio

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ****
  // properties
  // ****
  AST_RUN_GATE: assert property (wrCtl |-> ##2 secondDividerRun ==
    ($past(globalPllEnable) && $past(regWrData[2], 2) && !$past(regWrData[1], 2)))
    else $error("second divider run wrong");
  AST_BYP_SEL: assert property (wrCtl |-> ##2 outputBypassSelect == $past(regWrData[1], 2))
    else $error("bypass select wrong");
  AST_DIV_TWO: assert property (wrDiv |-> ##2 fastDividerTwoRatio == halfRatio($past(regWrData[7:4], 2)))
    else $error("second divider ratio wrong");
  AST_DIV_ONE: assert property (wrDiv |-> ##2 fastDividerOneRatio == halfRatio($past(regWrData[3:0], 2)))
    else $error("first divider ratio wrong");
  AST_PRI_INPUT: assert property (wrSrc && !regWrData[6] && regWrData[2:0] inside {3'h1, 3'h2, 3'h3}
    |-> ##2 pllRefSource == $past(regWrData[2:0], 2) && bypassSource == $past(regWrData[2:0], 2) + 3'h1)
    else $error("input routing wrong");
  AST_DPLL_PD: assert property (dpllPowerDownAllowed == (pllRefSource != APC_REF_DPLL))
    else $error("power-down flag disagrees with reference");
  // a step needs a cause: a control write two edges back or a pin change three edges back;
  // fast legal toggling may give steps on back-to-back cycles, so pulse width is not asserted
  AST_DEC_ONE: assert property (phaseDecStep |-> $past(wrPhase, 2) || $past(gpioPin, 3) != $past(gpioPin, 4))
    else $error("decrement step without a source change");
  AST_INC_ONE: assert property (phaseIncStep |-> $past(wrPhase, 2) || $past(gpioPin, 3) != $past(gpioPin, 4))
    else $error("increment step without a source change");
  AST_NUM_HOLD: assert property (!wrTop && !$past(wrTop) |=> $stable(feedbackNumerator))
    else $error("numerator moved without commit");
  AST_NUM_TOP: assert property (wrTop |-> ##2 feedbackNumerator[41:40] == $past(regWrData[1:0], 2))
    else $error("numerator top bits wrong");
endmodule : apc_path_control_checker

bind apc_path_control apc_path_control_checker chk (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
  .regWrEn(regWrEn), .regWrData(regWrData), .globalPllEnable(globalPllEnable), .gpioPin(gpioPin),
  .secondDividerRun(secondDividerRun), .outputBypassSelect(outputBypassSelect),
  .fastDividerOneRatio(fastDividerOneRatio), .fastDividerTwoRatio(fastDividerTwoRatio),
  .pllRefSource(pllRefSource), .bypassSource(bypassSource), .dpllPowerDownAllowed(dpllPowerDownAllowed),
  .phaseDecStep(phaseDecStep), .phaseIncStep(phaseIncStep), .feedbackNumerator(feedbackNumerator));

// ===== tb/test_apc_path_control.sv
module test_apc_path_control;
  timeunit 1ns;
  timeprecision 1ps;
  import apc_pkg::*;
  // ****
  // stimulus and observed signals
  // ****
  logic sys_clk, nrst, regWrEn, regRdEn, globalPllEnable, masterClockFromInputOne, crystalClockDoubler;
  logic [8:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [1:0] switchPinSelect;
  logic [3:0] gpioPin;
  logic secondDividerRun, outputBypassSelect, bypassDoubled, dpllPowerDownAllowed, phaseDecStep, phaseIncStep;
  apc_half_ratio_t fastDividerOneRatio, fastDividerTwoRatio;
  apc_ref_e pllRefSource;
  apc_byp_e bypassSource;
  apc_numerator_t feedbackNumerator;
  int failCount, samplesChecked;
  logic [7:0] decCnt, incCnt; // step pulses seen since last clear

  apc_path_control dut (.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .globalPllEnable(globalPllEnable),
    .masterClockFromInputOne(masterClockFromInputOne), .crystalClockDoubler(crystalClockDoubler),
    .switchPinSelect(switchPinSelect), .gpioPin(gpioPin), .secondDividerRun(secondDividerRun),
    .outputBypassSelect(outputBypassSelect), .fastDividerOneRatio(fastDividerOneRatio),
    .fastDividerTwoRatio(fastDividerTwoRatio), .pllRefSource(pllRefSource), .bypassSource(bypassSource),
    .bypassDoubled(bypassDoubled), .dpllPowerDownAllowed(dpllPowerDownAllowed),
    .phaseDecStep(phaseDecStep), .phaseIncStep(phaseIncStep), .feedbackNumerator(feedbackNumerator));

  // 50 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // count every step pulse, one cycle each
  always @(posedge sys_clk)
  begin
    if (phaseDecStep === 1'b1) decCnt <= decCnt + 8'h01;
    if (phaseIncStep === 1'b1) incCnt <= incCnt + 8'h01;
  end

  // ****
  // shared tasks
  // ****
  task automatic check(input logic [41:0] got, input logic [41:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      failCount++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  task automatic stopTest();
    if (failCount == 0 && samplesChecked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stopTest

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : wr

  // read data is registered, so look one cycle after the read edge
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    check(regRdData, exp);
  endtask : rd

  // outputs follow a write one cycle after the register
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  function automatic logic [41:0] ratioOf(input int c);
    return (c < 8) ? 42'(8 + c) : 42'(2 * c);
  endfunction : ratioOf

  // ****
  // scenarios
  // ****
  task automatic testReset();
    @(negedge sys_clk);
    check(secondDividerRun, 0);
    check(fastDividerOneRatio, 8);
    check(pllRefSource, APC_REF_CRYSTAL);
    check(dpllPowerDownAllowed, 1);
    check(feedbackNumerator, 0);
    for (int a = 0; a < 7; a++) rd(9'h100 + 9'(a), 8'h00);
  endtask : testReset

  task automatic testDividers();
    for (int c = 0; c < 16; c++)
    begin
      wr(9'h101, {4'(c), ~4'(c)});
      settle(2);
      check(fastDividerTwoRatio, ratioOf(c));
      check(fastDividerOneRatio, ratioOf(15 - c));
    end
    rd(9'h101, 8'hF0);
  endtask : testDividers

  task automatic testEnable();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      globalPllEnable <= i[2];
      wr(9'h100, {5'h1F, i[1], i[0], 1'b1});
      settle(2);
      check(secondDividerRun, i[2] & i[1] & ~i[0]);
      check(outputBypassSelect, i[0]);
      rd(9'h100, {5'h00, i[1], i[0], 1'b0});
    end
  endtask : testEnable

  // alternate field set but ignored while switching is off
  task automatic testSources();
    apc_ref_e refTab[8] = '{APC_REF_CRYSTAL, APC_REF_IN_ONE, APC_REF_IN_TWO, APC_REF_IN_THREE,
      APC_REF_DPLL, APC_REF_DPLL, APC_REF_DPLL, APC_REF_DPLL};
    apc_byp_e bypTab[8] = '{APC_BYP_CRYSTAL, APC_BYP_IN_ONE, APC_BYP_IN_TWO, APC_BYP_IN_THREE,
      APC_BYP_IN_ONE, APC_BYP_NONE, APC_BYP_CRYSTAL, APC_BYP_NONE};
    // bypass off first: codes 101 and 111 feed nothing to the bypass mux
    wr(9'h100, 8'h00);
    @(posedge sys_clk);
    masterClockFromInputOne <= 1'b1;
    crystalClockDoubler <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      wr(9'h102, {5'h17, 3'(c)});
      settle(2);
      check(pllRefSource, refTab[c]);
      check(bypassSource, bypTab[c]);
      check(dpllPowerDownAllowed, c < 4);
      rd(9'h102, {5'h07, 3'(c)});
    end
    check(bypassDoubled, 1);
    // without the input-one master clock code 100 feeds no bypass signal
    @(posedge sys_clk);
    masterClockFromInputOne <= 1'b0;
    wr(9'h102, 8'h04);
    settle(2);
    check(bypassSource, APC_BYP_NONE);
    // switch pin 2 low keeps primary, high hands over to alternate
    @(posedge sys_clk);
    switchPinSelect <= 2'h2;
    wr(9'h102, 8'h59);
    settle(4);
    check(pllRefSource, APC_REF_IN_ONE);
    @(posedge sys_clk);
    gpioPin <= 4'h4;
    for (int c = 0; c < 4; c++)
    begin
      wr(9'h102, {2'b01, 3'(c), 3'h1});
      settle(4);
      check(pllRefSource, refTab[c]);
    end
    wr(9'h102, 8'h19);
    settle(2);
    check(pllRefSource, APC_REF_IN_ONE);
    @(posedge sys_clk);
    gpioPin <= 4'h0;
  endtask : testSources

  // two transitions of the chosen source must give two steps
  task automatic stepRun(input logic [7:0] s0, input logic [7:0] s1, input logic [3:0] pins,
    input int expDec, input int expInc);
    wr(9'h103, s0);
    settle(6);
    decCnt <= 8'h00;
    incCnt <= 8'h00;
    wr(9'h103, s1);
    gpioPin <= gpioPin ^ pins;
    settle(6);
    wr(9'h103, s0);
    gpioPin <= gpioPin ^ pins;
    settle(6);
    check(decCnt, expDec);
    check(incCnt, expInc);
  endtask : stepRun

  task automatic testSteps();
    for (int k = 0; k < 4; k++)
    begin
      stepRun({1'b0, 3'(k + 1), 4'h5}, {1'b0, 3'(k + 1), 4'h5}, 4'h1 << k, 2, 0);
      stepRun({4'h5, 1'b0, 3'(k + 1)}, {4'h5, 1'b0, 3'(k + 1)}, 4'h1 << k, 0, 2);
      stepRun(8'h77, 8'h77, 4'h1 << k, 0, 0);
    end
    stepRun(8'h05, 8'h85, 4'h0, 2, 0);
    stepRun(8'h50, 8'h58, 4'h0, 0, 2);
    stepRun(8'h11, 8'h99, 4'h0, 0, 0);
  endtask : testSteps

  // staged bytes stay hidden until the top byte lands
  task automatic testNumerator();
    for (int i = 0; i < 5; i++) wr(9'h106 + 9'(i), 8'hA0 + 8'(i));
    settle(2);
    check(feedbackNumerator, 0);
    // nonzero value; top bits 11 are allowed since the loop runs from input one, not the DPLL
    wr(9'h10B, 8'hFF);
    settle(2);
    check(feedbackNumerator, {2'b11, 40'hA4A3A2A1A0});
    rd(9'h10B, 8'h03);
    rd(9'h108, 8'hA2);
    wr(9'h104, 8'hFF);
    rd(9'h104, 8'h00);
    // denominator lives outside this block, so its offset reads zero here
    rd(9'h10C, 8'h00);
  endtask : testNumerator

  // ****
  // main sequence
  // ****
  initial
  begin
    {nrst, regWrEn, regRdEn, globalPllEnable, masterClockFromInputOne, crystalClockDoubler} = 6'h00;
    regAddr = 9'h000;
    regWrData = 8'h00;
    switchPinSelect = 2'h0;
    gpioPin = 4'h0;
    failCount = 0;
    samplesChecked = 0;
    decCnt = 8'h00;
    incCnt = 8'h00;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    testReset();
    testDividers();
    testEnable();
    testSources();
    testSteps();
    testNumerator();
    stopTest();
  end
endmodule : test_apc_path_control
